// >>> cud_top.sv
// cud_top.sv: command-unit command decoder of a LAN controller: the
// register port, the command-unit sequencer and the dump control.
// assumes: one 100 MHz clock; the command-block engine and the memory
// writer sit on the same clock and never stall this block.
`include "cud_defs.svh"

module cud_top
   import cud_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic BLK_FETCH,
   output logic [31:0] BLK_ADDR,
   output logic BLK_HIGH,
   input wire logic BLK_DONE,
   input wire logic BLK_SUSPEND,
   input wire logic BLK_END,
   input wire logic [31:0] BLK_NEXT,
   input wire logic [`CUD_NCNT-1:0] STAT_EVT,
   output logic DUMP_WR,
   output logic [31:0] DUMP_ADDR,
   output logic [31:0] DUMP_DATA,
   output logic DUMP_BUSY
);

   // ****************************************************************
   // register port
   // ****************************************************************
   logic [31:0] gp_r, gp_nxt;
   logic [7:0] msk_r, msk_nxt;
   logic [2:0] ruc_r, ruc_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic cmd_wr;
   logic [`CUD_NCNT*32-1:0] cnt_all;
   logic [`CUD_CIDX_W-1:0] cnt_sel;

   // sequencer state, declared here so the read mux can show it
   cud_state_t st_r, st_nxt;
   logic [31:0] base_r, base_nxt;
   logic [31:0] daddr_r, daddr_nxt;
   logic daddr_ok_r, daddr_ok_nxt;
   logic hp_seen_r, hp_seen_nxt;
   logic res_pend_r, res_pend_nxt;
   logic dump_lost_r, dump_lost_nxt;
   logic [31:0] next_r, next_nxt;
   logic [31:0] hp_first_r, hp_first_nxt;
   logic fetch_r, fetch_nxt;
   logic [31:0] cbaddr_r, cbaddr_nxt;
   logic cbhpq_r, cbhpq_nxt;
   logic dump_go, dump_clr, dump_busy;
   logic cmd_go;
   logic [3:0] cmd_op;

   function automatic logic [1:0] sts_code(input cud_state_t s);
      case (s)
         CUD_ST_SUSP: sts_code = `CUD_STS_SUSP;
         CUD_ST_NORM: sts_code = `CUD_STS_NORM;
         CUD_ST_HIGH: sts_code = `CUD_STS_HIGH;
         default: sts_code = `CUD_STS_IDLE;
      endcase
   endfunction : sts_code

   assign cmd_wr = WR && (ADDR == `CUD_OFS_CMD);
   assign cnt_sel = ADDR[`CUD_CIDX_W+1:2];

   always_comb
   begin
      gp_nxt = gp_r;
      msk_nxt = msk_r;
      ruc_nxt = ruc_r;
      rdata_nxt = `CUD_RST_WORD;
      if (WR && ADDR == `CUD_OFS_GP)
         gp_nxt = WDATA;
      if (cmd_wr)
      begin
         msk_nxt = WDATA[`CUD_MSK_MSB:`CUD_MSK_LSB];
         // the software interrupt bit is write-only and never sticks
         msk_nxt[`CUD_SWI_BIT-`CUD_MSK_LSB] = 1'b0;
         ruc_nxt = WDATA[`CUD_RUC_MSB:`CUD_RUC_LSB];
      end
      if (RD)
      begin
         if (ADDR == `CUD_OFS_STAT)
            rdata_nxt[`CUD_STSF_MSB:`CUD_STSF_LSB] = sts_code(st_r);
         else if (ADDR == `CUD_OFS_CMD)
         begin
            // the command field is taken at once, so it reads back zero
            rdata_nxt[`CUD_MSK_MSB:`CUD_MSK_LSB] = msk_r;
            rdata_nxt[`CUD_RUC_MSB:`CUD_RUC_LSB] = ruc_r;
         end
         else if (ADDR == `CUD_OFS_GP)
            rdata_nxt = gp_r;
         else if (ADDR == `CUD_OFS_BASE)
            rdata_nxt = base_r;
         else if (ADDR == `CUD_OFS_DADDR)
            rdata_nxt = daddr_r;
         else if (ADDR == `CUD_OFS_CTRL)
            rdata_nxt[3:0] = {dump_lost_r, res_pend_r, hp_seen_r,
                              daddr_ok_r};
         else if (ADDR >= `CUD_OFS_CNT && ADDR <= `CUD_OFS_CNT_END
                  && ADDR[1:0] == 2'h0)
            rdata_nxt = cnt_all[cnt_sel*32 +: 32];
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         gp_r <= `CUD_RST_WORD;
         msk_r <= 8'h00;
         ruc_r <= 3'h0;
         rdata_r <= `CUD_RST_WORD;
      end
      else
      begin
         gp_r <= gp_nxt;
         msk_r <= msk_nxt;
         ruc_r <= ruc_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************************************
   // opcode capture
   // ****************************************************************
   cud_cmd_dec u_dec
   (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .wr(cmd_wr),
      .op(WDATA[`CUD_CMDF_MSB:`CUD_CMDF_LSB]),
      .go(cmd_go),
      .op_out(cmd_op)
   );

   // ****************************************************************
   // command unit sequencer
   // ****************************************************************
   always_comb
   begin
      st_nxt = st_r;
      base_nxt = base_r;
      daddr_nxt = daddr_r;
      daddr_ok_nxt = daddr_ok_r;
      hp_seen_nxt = hp_seen_r;
      res_pend_nxt = res_pend_r;
      dump_lost_nxt = dump_lost_r;
      next_nxt = next_r;
      hp_first_nxt = hp_first_r;
      fetch_nxt = 1'b0;
      cbaddr_nxt = cbaddr_r;
      cbhpq_nxt = cbhpq_r;
      dump_go = 1'b0;
      dump_clr = 1'b0;

      // block finished: move along the list, park, or go idle
      if (BLK_DONE && (st_r == CUD_ST_NORM || st_r == CUD_ST_HIGH))
      begin
         next_nxt = BLK_NEXT;
         if (BLK_END)
         begin
            st_nxt = CUD_ST_IDLE;
            res_pend_nxt = 1'b0;
         end
         else if (BLK_SUSPEND && !res_pend_r)
            st_nxt = CUD_ST_SUSP;
         else
         begin
            // a resume that came while busy carries past the suspend
            res_pend_nxt = 1'b0;
            fetch_nxt = 1'b1;
            cbaddr_nxt = BLK_NEXT;
         end
      end

      // a start, high start, or high resume once a high start was seen, in the same cycle overrides the block bookkeeping; a resume reads its outcome
      if (cmd_go)
      begin
         case (cmd_op)
            `CUD_OP_START:
            begin
               st_nxt = CUD_ST_NORM;
               fetch_nxt = 1'b1;
               cbaddr_nxt = cud_addr(base_r, gp_r);
               cbhpq_nxt = 1'b0;
               res_pend_nxt = 1'b0;
            end
            `CUD_OP_RESUME, `CUD_OP_STAT_RES:
            begin
               if (st_r == CUD_ST_SUSP)
               begin
                  st_nxt = cbhpq_r ? CUD_ST_HIGH : CUD_ST_NORM;
                  fetch_nxt = 1'b1;
                  cbaddr_nxt = next_r;
               end
               else if (st_nxt == CUD_ST_SUSP && cmd_op == `CUD_OP_RESUME)
               begin
                  // the block parks this very cycle: run on past it now
                  st_nxt = st_r;
                  fetch_nxt = 1'b1;
                  cbaddr_nxt = BLK_NEXT;
               end
               else if (st_nxt != CUD_ST_IDLE && cmd_op == `CUD_OP_RESUME)
                  res_pend_nxt = 1'b1;
            end
            `CUD_OP_HP_START:
            begin
               st_nxt = CUD_ST_HIGH;
               fetch_nxt = 1'b1;
               cbaddr_nxt = cud_addr(base_r, gp_r);
               hp_first_nxt = cud_addr(base_r, gp_r);
               cbhpq_nxt = 1'b1;
               hp_seen_nxt = 1'b1;
               res_pend_nxt = 1'b0;
            end
            `CUD_OP_HP_RES:
            begin
               if (hp_seen_r)
               begin
                  st_nxt = CUD_ST_HIGH;
                  fetch_nxt = 1'b1;
                  cbaddr_nxt = hp_first_r;
                  cbhpq_nxt = 1'b1;
               end
            end
            `CUD_OP_LD_DUMP:
            begin
               daddr_nxt = gp_r;
               daddr_ok_nxt = 1'b1;
            end
            `CUD_OP_LD_BASE:
               base_nxt = gp_r;
            `CUD_OP_DUMP, `CUD_OP_DUMP_CLR:
            begin
               // a dump with no area loaded or while one runs is dropped
               if (daddr_ok_r && !dump_busy)
               begin
                  dump_go = 1'b1;
                  dump_clr = (cmd_op == `CUD_OP_DUMP_CLR);
               end
               else
                  dump_lost_nxt = 1'b1;
            end
            default:
               st_nxt = st_r;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         st_r <= CUD_ST_IDLE;
         base_r <= `CUD_RST_WORD;
         daddr_r <= `CUD_RST_WORD;
         daddr_ok_r <= 1'b0;
         hp_seen_r <= 1'b0;
         res_pend_r <= 1'b0;
         dump_lost_r <= 1'b0;
         next_r <= `CUD_RST_WORD;
         hp_first_r <= `CUD_RST_WORD;
         fetch_r <= 1'b0;
         cbaddr_r <= `CUD_RST_WORD;
         cbhpq_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         base_r <= base_nxt;
         daddr_r <= daddr_nxt;
         daddr_ok_r <= daddr_ok_nxt;
         hp_seen_r <= hp_seen_nxt;
         res_pend_r <= res_pend_nxt;
         dump_lost_r <= dump_lost_nxt;
         next_r <= next_nxt;
         hp_first_r <= hp_first_nxt;
         fetch_r <= fetch_nxt;
         cbaddr_r <= cbaddr_nxt;
         cbhpq_r <= cbhpq_nxt;
      end
   end

   // ****************************************************************
   // statistical counters
   // ****************************************************************
   cud_stats u_stats
   (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .evt(STAT_EVT),
      .dump_go(dump_go),
      .dump_clr(dump_clr),
      .dump_base(daddr_r),
      .busy(dump_busy),
      .mem_wr(DUMP_WR),
      .mem_addr(DUMP_ADDR),
      .mem_data(DUMP_DATA),
      .cnt_all(cnt_all)
   );

   assign RDATA = rdata_r;
   assign BLK_FETCH = fetch_r;
   assign BLK_ADDR = cbaddr_r;
   assign BLK_HIGH = cbhpq_r;
   assign DUMP_BUSY = dump_busy;

endmodule : cud_top

// >>> cud_defs.svh
// cud_defs.svh: offsets, field positions, opcodes and sizes of the
// command-unit decoder.
// assumes: included by the package and design files by bare name.
`ifndef CUD_DEFS_SVH
`define CUD_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses on the plain register port)
// ****************************************************************
`define CUD_OFS_STAT 8'h00
`define CUD_OFS_CMD 8'h02
`define CUD_OFS_GP 8'h04
`define CUD_OFS_BASE 8'h10
`define CUD_OFS_DADDR 8'h14
`define CUD_OFS_CTRL 8'h18
`define CUD_OFS_CNT 8'h20
`define CUD_OFS_CNT_END 8'h2c

// ****************************************************************
// fields
// ****************************************************************
`define CUD_CMDF_MSB 7
`define CUD_CMDF_LSB 4
`define CUD_STSF_MSB 7
`define CUD_STSF_LSB 6
`define CUD_RUC_MSB 2
`define CUD_RUC_LSB 0
`define CUD_MSK_MSB 15
`define CUD_MSK_LSB 8
`define CUD_SWI_BIT 9

// ****************************************************************
// command unit opcodes
// ****************************************************************
`define CUD_OP_NOP 4'h0
`define CUD_OP_START 4'h1
`define CUD_OP_RESUME 4'h2
`define CUD_OP_HP_START 4'h3
`define CUD_OP_LD_DUMP 4'h4
`define CUD_OP_DUMP 4'h5
`define CUD_OP_LD_BASE 4'h6
`define CUD_OP_DUMP_CLR 4'h7
`define CUD_OP_STAT_RES 4'ha
`define CUD_OP_HP_RES 4'hb

// ****************************************************************
// status codes and sizes
// ****************************************************************
`define CUD_STS_IDLE 2'h0
`define CUD_STS_SUSP 2'h1
`define CUD_STS_NORM 2'h2
`define CUD_STS_HIGH 2'h3
`define CUD_NCNT 4
`define CUD_CIDX_W 2
`define CUD_WORD_STEP 32'h0000_0004
`define CUD_RST_WORD 32'h0000_0000

`endif

// >>> cud_pkg.sv
// cud_pkg.sv: types and shared functions of the command-unit decoder.
// assumes: cud_defs.svh is on the include path.
`include "cud_defs.svh"

package cud_pkg;

   typedef enum logic [3:0]
   {
      CUD_ST_IDLE = 4'b0001,
      CUD_ST_SUSP = 4'b0010,
      CUD_ST_NORM = 4'b0100,
      CUD_ST_HIGH = 4'b1000
   } cud_state_t;

   // unlisted encodings are reserved and must do nothing
   function automatic logic cud_op_known(input logic [3:0] op);
      case (op)
         `CUD_OP_NOP, `CUD_OP_START, `CUD_OP_RESUME, `CUD_OP_HP_START,
         `CUD_OP_LD_DUMP, `CUD_OP_DUMP, `CUD_OP_LD_BASE,
         `CUD_OP_DUMP_CLR, `CUD_OP_STAT_RES, `CUD_OP_HP_RES:
            cud_op_known = 1'b1;
         default:
            cud_op_known = 1'b0;
      endcase
   endfunction : cud_op_known

   function automatic logic [31:0] cud_addr(input logic [31:0] base,
                                            input logic [31:0] ofs);
      cud_addr = base + ofs;
   endfunction : cud_addr

endpackage : cud_pkg

// >>> cud_cmd_dec.sv
// cud_cmd_dec.sv: catches a write of the command field and hands one
// registered opcode pulse to the command-unit sequencer.
// assumes: wr and op come from logic on the same clock.
module cud_cmd_dec
   import cud_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic [3:0] op,
   output logic go,
   output logic [3:0] op_out
);

   logic go_r;
   logic go_nxt;
   logic [3:0] op_r;
   logic [3:0] op_nxt;

   always_comb
   begin
      // reserved codes and the no-operation code never raise go; op_out still follows every write
      go_nxt = wr && cud_op_known(op) && (op != `CUD_OP_NOP);
      op_nxt = wr ? op : op_r;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         go_r <= 1'b0;
         op_r <= `CUD_OP_NOP;
      end
      else
      begin
         go_r <= go_nxt;
         op_r <= op_nxt;
      end
   end

   assign go = go_r;
   assign op_out = op_r;

endmodule : cud_cmd_dec

// >>> cud_stats.sv
// cud_stats.sv: statistical counters and the engine that writes them
// out, one word per cycle, to the dump area.
// assumes: events and commands are on the same clock; the memory side
// takes one word per cycle without stalling.
module cud_stats
   import cud_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`CUD_NCNT-1:0] evt,
   input wire logic dump_go,
   input wire logic dump_clr,
   input wire logic [31:0] dump_base,
   output logic busy,
   output logic mem_wr,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_data,
   output logic [`CUD_NCNT*32-1:0] cnt_all
);

   logic [31:0] cnt_r [`CUD_NCNT];
   logic [31:0] cnt_nxt [`CUD_NCNT];
   logic busy_r, busy_nxt, clr_r, clr_nxt, wr_r, wr_nxt;
   logic [`CUD_CIDX_W-1:0] idx_r, idx_nxt;
   logic [31:0] addr_r, addr_nxt, data_r, data_nxt;

   always_comb
   begin
      busy_nxt = busy_r;
      clr_nxt = clr_r;
      idx_nxt = idx_r;
      wr_nxt = 1'b0;
      addr_nxt = addr_r;
      data_nxt = data_r;
      for (int i = 0; i < `CUD_NCNT; i++)
         cnt_nxt[i] = evt[i] ? cnt_r[i] + 32'h1 : cnt_r[i];
      if (dump_go && !busy_r)
      begin
         busy_nxt = 1'b1;
         clr_nxt = dump_clr;
         idx_nxt = '0;
         addr_nxt = dump_base;
      end
      else if (busy_r)
      begin
         wr_nxt = 1'b1;
         data_nxt = cnt_r[idx_r];
         addr_nxt = wr_r ? cud_addr(addr_r, `CUD_WORD_STEP) : addr_r;
         idx_nxt = idx_r + 1'b1;
         if (idx_r == `CUD_CIDX_W'(`CUD_NCNT - 1))
         begin
            busy_nxt = 1'b0;
            // the clear lands on the same edge that takes the last word
            if (clr_r)
               for (int i = 0; i < `CUD_NCNT; i++)
                  cnt_nxt[i] = `CUD_RST_WORD;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_r <= 1'b0;
         clr_r <= 1'b0;
         idx_r <= '0;
         wr_r <= 1'b0;
         addr_r <= `CUD_RST_WORD;
         data_r <= `CUD_RST_WORD;
         for (int i = 0; i < `CUD_NCNT; i++)
            cnt_r[i] <= `CUD_RST_WORD;
      end
      else
      begin
         busy_r <= busy_nxt;
         clr_r <= clr_nxt;
         idx_r <= idx_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         for (int i = 0; i < `CUD_NCNT; i++)
            cnt_r[i] <= cnt_nxt[i];
      end
   end

   always_comb
   begin
      for (int i = 0; i < `CUD_NCNT; i++)
         cnt_all[i*32 +: 32] = cnt_r[i];
   end

   assign busy = busy_r;
   assign mem_wr = wr_r;
   assign mem_addr = addr_r;
   assign mem_data = data_r;

endmodule : cud_stats

// >>> cud_properties.sv
// cud_properties.sv: port-level checks of the command-unit decoder.
// assumes: bound into cud_top; one clock, async active-low reset.
`include "cud_defs.svh"

module cud_props
(
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic BLK_FETCH,
   input wire logic [31:0] BLK_ADDR,
   input wire logic BLK_HIGH,
   input wire logic DUMP_WR,
   input wire logic [31:0] DUMP_ADDR,
   input wire logic DUMP_BUSY
);
   default clocking cud_clk @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);

   // ********
   // shadow of what software loaded
   // ********
   logic [31:0] gp_q, base_q, dadr_q, hpa_q, exp_w;
   logic [3:0] op_w, op_q;
   logic cmd_w, dmp_w, cp_q, ld_q, run_q, hps_q, ldn_w;
   assign op_w = WDATA[7:4];
   assign cmd_w = WR && ADDR == `CUD_OFS_CMD;
   assign dmp_w = cmd_w && (op_w == `CUD_OP_DUMP || op_w == `CUD_OP_DUMP_CLR);
   assign exp_w = base_q + gp_q;
   // a command acts one edge after its write, so the shadow lags too
   assign ldn_w = ld_q || (cp_q && op_q == `CUD_OP_LD_DUMP);
   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         {gp_q, base_q, dadr_q, hpa_q} <= '0;
         {op_q, cp_q, ld_q, run_q, hps_q} <= '0;
      end
      else
      begin
         cp_q <= cmd_w;
         op_q <= op_w;
         if (WR && ADDR == `CUD_OFS_GP)
            gp_q <= WDATA;
         if (cmd_w && (op_w == `CUD_OP_START || op_w == `CUD_OP_HP_START))
            run_q <= 1'b1;
         if (cp_q && op_q == `CUD_OP_LD_BASE)
            base_q <= gp_q;
         if (cp_q && op_q == `CUD_OP_LD_DUMP)
            {dadr_q, ld_q} <= {gp_q, 1'b1};
         if (cp_q && op_q == `CUD_OP_HP_START)
            {hpa_q, hps_q} <= {exp_w, 1'b1};
      end
   end

   // ********
   // properties
   // ********
   sequence s_words;
      DUMP_WR && DUMP_ADDR == dadr_q ##1
      DUMP_WR && DUMP_ADDR == dadr_q + 32'h4 ##1
      DUMP_WR && DUMP_ADDR == dadr_q + 32'h8 ##1
      DUMP_WR && DUMP_ADDR == dadr_q + 32'hc ##1 !DUMP_WR;
   endsequence

   a_start_fetch: assert property (
      cmd_w && op_w == `CUD_OP_START |->
      ##2 BLK_FETCH && !BLK_HIGH && BLK_ADDR == $past(exp_w))
      else $error("start did not fetch the first block");
   a_hp_fetch: assert property (
      cmd_w && op_w == `CUD_OP_HP_START |->
      ##2 BLK_FETCH && BLK_HIGH && BLK_ADDR == $past(exp_w))
      else $error("high start did not fetch the first block");
   a_idle_ignore: assert property (
      cmd_w && !run_q && op_w != `CUD_OP_START &&
      op_w != `CUD_OP_HP_START |-> ##2 !BLK_FETCH)
      else $error("command fetched while idle");
   a_hp_resume: assert property (
      cmd_w && op_w == `CUD_OP_HP_RES && hps_q |->
      ##2 BLK_FETCH && BLK_HIGH && BLK_ADDR == hpa_q)
      else $error("high resume missed the first high block");
   a_dump_busy: assert property (
      dmp_w && ldn_w && !DUMP_BUSY && !$past(dmp_w) |->
      ##2 DUMP_BUSY [*4] ##1 !DUMP_BUSY)
      else $error("dump busy window wrong");
   a_dump_words: assert property (
      dmp_w && ldn_w && !DUMP_BUSY && !$past(dmp_w) |-> ##3 s_words)
      else $error("dump words wrong");
   a_dump_drop: assert property (
      dmp_w && !ldn_w |-> ##1 (!DUMP_BUSY) [*5])
      else $error("dump ran without a dump address");
   a_gp_read: assert property (
      RD && ADDR == `CUD_OFS_GP |=> RDATA == $past(gp_q))
      else $error("general pointer read wrong");
   a_base_read: assert property (
      RD && ADDR == `CUD_OFS_BASE |=> RDATA == $past(base_q))
      else $error("base read wrong");

   c_hp_res: cover property (cmd_w && op_w == `CUD_OP_HP_RES && hps_q);
   c_dump: cover property (DUMP_WR && DUMP_ADDR == dadr_q + 32'hc);
   c_norm: cover property (BLK_FETCH && !BLK_HIGH);
endmodule : cud_props

bind cud_top cud_props chk_u (.REF_CLK, .RESET_N, .ADDR, .WDATA, .WR,
   .RD, .RDATA, .BLK_FETCH, .BLK_ADDR, .BLK_HIGH, .DUMP_WR, .DUMP_ADDR,
   .DUMP_BUSY);

// >>> tb.sv
// tb.sv: self-checking bench of the command-unit decoder.
// assumes: cud_pkg and cud_top compiled first; bench plays the engine.
`include "cud_defs.svh"
`define TB_CHK(g, e, m) \
   begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("Error %0t: %s", $time, m); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [3:0] k, op; logic [11:0] v;
      logic [3:0] se, f; logic [11:0] fa; logic [3:0] h, st;} cud_row_t;
   // k op v se f fa h st; se = suspend, end; v = pointer or next
   cud_row_t rows [21] = '{
      48'h0_2_000_0_0_000_0_0, 48'h0_a_000_0_0_000_0_0,
      48'h0_b_000_0_0_000_0_0, 48'h0_0_000_0_0_000_0_0,
      48'h0_6_100_0_0_000_0_0, 48'h0_1_040_0_1_140_0_2,
      48'h1_0_200_0_1_200_0_2, 48'h1_0_300_2_0_000_0_1,
      48'h0_a_000_0_1_300_0_2, 48'h0_2_000_0_0_000_0_2,
      48'h1_0_380_2_1_380_0_2, 48'h1_0_3c0_2_0_000_0_1,
      48'h0_2_000_0_1_3c0_0_2, 48'h0_a_000_0_0_000_0_2,
      48'h1_0_400_2_0_000_0_1, 48'h0_3_080_0_1_180_1_3,
      48'h0_0_000_0_0_000_0_3, 48'h0_b_000_0_1_180_1_3,
      48'h1_0_000_1_0_000_0_0, 48'h0_2_000_0_0_000_0_0,
      48'h0_8_000_0_0_000_0_0};
   logic [7:0] raddr [11] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h14,
      8'h18, 8'h20, 8'h24, 8'h28, 8'h2c};
   logic REF_CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic BLK_DONE = 1'b0;
   logic BLK_SUSPEND = 1'b0;
   logic BLK_END = 1'b0;
   logic [31:0] BLK_NEXT = 32'h0;
   logic [3:0] STAT_EVT = 4'h0;
   logic [31:0] RDATA, BLK_ADDR, DUMP_ADDR, DUMP_DATA;
   logic BLK_FETCH, BLK_HIGH, DUMP_WR, DUMP_BUSY;
   int err_count = 0;
   int total_checks = 0;
   int cyc_count = 0;

   cud_top dut_u (.REF_CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
      .BLK_FETCH, .BLK_ADDR, .BLK_HIGH, .BLK_DONE, .BLK_SUSPEND, .BLK_END,
      .BLK_NEXT, .STAT_EVT, .DUMP_WR, .DUMP_ADDR, .DUMP_DATA, .DUMP_BUSY);

   always #5 REF_CLK = ~REF_CLK;

   // ********
   // bus and engine tasks
   // ********
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask : wr

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge REF_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1;
      `TB_CHK(RDATA, e, "register read")
   endtask : chk_rd

   // released engine lines carry the inverse so stale values never help
   task automatic done(input logic [3:0] se, input logic [31:0] nx);
      @(posedge REF_CLK);
      {BLK_DONE, BLK_SUSPEND, BLK_END, BLK_NEXT} <= {1'b1, se[1:0], nx};
      @(posedge REF_CLK);
      {BLK_DONE, BLK_SUSPEND, BLK_END, BLK_NEXT} <= {1'b0, ~se[1:0], ~nx};
   endtask : done

   task automatic watch(output logic [3:0] n, output logic [31:0] a,
                        output logic h);
      // a block-done fetch rises on the edge that ends the done task
      {n, a, h} = '0;
      repeat (5)
      begin
         #1;
         if (BLK_FETCH === 1'b1)
            {n, a, h} = {n + 4'h1, BLK_ADDR, BLK_HIGH};
         @(posedge REF_CLK);
      end
   endtask : watch

   task automatic dumpw(output logic [3:0] n);
      n = 4'h0;
      repeat (12)
      begin
         @(posedge REF_CLK);
         #1;
         if (DUMP_WR === 1'b1)
         begin
            `TB_CHK(DUMP_ADDR, 32'h1000 + {n, 2'b00}, "dump addr")
            `TB_CHK(DUMP_DATA, 32'h4 - n, "dump data")
            `TB_CHK(DUMP_BUSY, n != 4'h3, "dump busy")
            n = n + 4'h1;
         end
      end
   endtask : dumpw

   task automatic chk_cnt(input logic clr);
      for (int k = 0; k < 4; k++)
         chk_rd(`CUD_OFS_CNT + 8'(4 * k), clr ? 32'h0 : 32'(4 - k));
   endtask : chk_cnt

   always @(posedge REF_CLK)
   begin
      cyc_count++;
      if (cyc_count == 5000)
      begin
         err_count++;
         $display("Error %0t: run did not finish", $time);
         stop_test();
      end
   end

   // ********
   // main sequence
   // ********
   initial
   begin
      cud_row_t r;
      logic [3:0] n;
      logic [31:0] a;
      logic h;
      repeat (4) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      foreach (raddr[i])
         chk_rd(raddr[i], 32'h0);
      wr(`CUD_OFS_CMD, 32'h0000_ff07);
      chk_rd(`CUD_OFS_CMD, 32'h0000_fd07);
      foreach (rows[i])
      begin
         r = rows[i];
         if (r.k == 4'h0)
         begin
            wr(`CUD_OFS_GP, {20'h0, r.v});
            wr(`CUD_OFS_CMD, {24'h0, r.op, 4'h0});
         end
         else
            done(r.se, {20'h0, r.v});
         watch(n, a, h);
         `TB_CHK(n, r.f, "fetch count")
         if (r.f == 4'h1)
         begin
            `TB_CHK(a, {20'h0, r.fa}, "fetch addr")
            `TB_CHK(h, r.h[0], "list select")
         end
         chk_rd(`CUD_OFS_STAT, {24'h0, r.st[1:0], 6'h0});
      end
      for (int i = 8; i < 16; i++)
         if (i != 10 && i != 11)
         begin
            wr(`CUD_OFS_CMD, 32'(i << 4));
            watch(n, a, h);
            `TB_CHK(n, 4'h0, "reserved fetched")
            chk_rd(`CUD_OFS_STAT, 32'h0);
         end
      chk_rd(`CUD_OFS_BASE, 32'h100);
      wr(`CUD_OFS_BASE, 32'hffff_ffff);
      chk_rd(`CUD_OFS_BASE, 32'h100);
      wr(8'h08, 32'h5a5a_5a5a);
      chk_rd(8'h08, 32'h0);
      wr(`CUD_OFS_CMD, 32'h50);
      dumpw(n);
      `TB_CHK(n, 4'h0, "dump ran unloaded")
      chk_rd(`CUD_OFS_CTRL, 32'ha);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge REF_CLK);
         STAT_EVT <= 4'hf >> i;
      end
      chk_cnt(1'b0);
      wr(`CUD_OFS_GP, 32'h1000);
      wr(`CUD_OFS_CMD, 32'h40);
      chk_rd(`CUD_OFS_DADDR, 32'h1000);
      chk_rd(`CUD_OFS_CTRL, 32'hb);
      chk_rd(`CUD_OFS_GP, 32'h1000);
      wr(`CUD_OFS_CMD, 32'h50);
      dumpw(n);
      `TB_CHK(n, 4'h4, "dump words")
      chk_cnt(1'b0);
      // a dump issued while one runs must be dropped, not queued
      @(posedge REF_CLK);
      {ADDR, WDATA, WR} <= {`CUD_OFS_CMD, 32'h70, 1'b1};
      @(posedge REF_CLK);
      WDATA <= 32'h50;
      @(posedge REF_CLK);
      WR <= 1'b0;
      dumpw(n);
      `TB_CHK(n, 4'h4, "dump and clear words")
      chk_cnt(1'b1);
      @(posedge REF_CLK);
      RESET_N <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      chk_rd(`CUD_OFS_CTRL, 32'h0);
      wr(`CUD_OFS_CMD, 32'hb0);
      watch(n, a, h);
      `TB_CHK(n, 4'h0, "high resume before high start")
      chk_rd(`CUD_OFS_STAT, 32'h0);
      stop_test();
   end
endmodule : tb
